// >>> ptc_chk.sv
`timescale 1ns/10ps
module ptc_chk (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic gate_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire ptc_pkg::ptc_lamps_s lamps_o,
    input wire logic gate_level_out_o,
    input wire logic overflow_pulse_out_o
);
    // ----------------------------------------
    // Pulse length counter
    // ----------------------------------------
    logic [9:0] hi_q;
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i || !overflow_pulse_out_o) begin
            hi_q <= 10'h000;
        end else begin
            hi_q <= hi_q + 10'h001;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    sequence mode_wr;
        wr_i && addr_i == 8'h04;
    endsequence
    sequence mode_rd;
        rd_i && addr_i == 8'h04;
    endsequence
    a_ovf_width: assert property ($fell(overflow_pulse_out_o) |-> hi_q == 10'h1F4)
        else $error("overflow pulse length wrong");
    a_ovf_bound: assert property (hi_q <= 10'h1F4)
        else $error("overflow pulse too long");
    a_ovf_lamp_set: assert property ($rose(overflow_pulse_out_o) |-> lamps_o.overflow_lamp)
        else $error("pulse without overflow lamp");
    a_gate_low_blocks: assert property ((!gate_i) [*5] |-> !gate_level_out_o && !lamps_o.gate_lamp)
        else $error("counting while gate low");
    a_lamps_onehot: assert property ($onehot(lamps_o.disp) && $onehot(lamps_o.tb) && $onehot(lamps_o.sel))
        else $error("lamp group not one-hot");
    a_sel_in_preset: assert property ($changed(lamps_o.sel) |-> $past(lamps_o.disp) == ptc_pkg::PTC_DISP_PRESET)
        else $error("digit select moved outside preset view");
    a_stop_drops_gate: assert property (wr_i && addr_i == 8'h00 && wdata_i[1] |-> ##[1:2] !gate_level_out_o)
        else $error("stop did not end counting");
    a_remote_lamp_on: assert property (mode_wr ##0 wdata_i[0] |-> ##[1:2] lamps_o.remote_lamp)
        else $error("remote lamp not lit");
    a_mode_readback: assert property (mode_wr ##2 mode_rd |=> rdata_o[2:0] == $past(wdata_i[2:0], 3))
        else $error("mode read back wrong");
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data outside read cycle");
endmodule
bind ptc_top ptc_chk i_ptc_chk (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .gate_i(gate_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .lamps_o(lamps_o),
    .gate_level_out_o(gate_level_out_o), .overflow_pulse_out_o(overflow_pulse_out_o));

// >>> ptc_map.svh
// Notes on behaviour
// - Show eight digits, blank leading zeros, two decimals when showing time.
// - Overflow lamp sets when counter passes eight decades, stays until reset.
// - Select button steps active preset digit, only while preset is displayed.
// - Advance button adds one to active digit; mantissa 0-9, exponent 0-6.
// - Advance button ignored unless the preset value is displayed.
// - Display button toggles counter or preset view, one lamp each.
// - Time-base button cycles 0.01 s, 0.01 min and external events.
// - Stop halts counter and preset register alike.
// - Reset clears counter to zero and the overflow lamp.
// - Reset clears preset register counts, keeps the preset digits.
// - A reset is generated at power-up; the code takes reset from the reset_n_i input.
// - Count enables counting while gate not low and preset not reached.
// - Gate lamp on only when counting, gate high, preset not reached.
// - Remote lock lights remote lamp and disables all panel buttons.
// - Without recycle, stop at interval end and hold counts until reset.
// - With recycle jumper, dwell 1 or 10 s, then reset and run again.
// - Dwell and recycle disabled under print-loop or computer control.
// - Source jumper picks events always, or ticks unless external base.
// - Auto restart latches counter to buffer, clears counters, runs on.
// - Single interval mode stops at preset and waits for commands.
// - One pulse of about 20 us on each counter overflow.
// - Interval output high while counting, low otherwise.
// - Stop when preset register reaches mantissa times ten to exponent.
// - Zero mantissa disables the preset stop.
// - Power-up clears counters, shows counts, zero digits, 0.01 s base.
`ifndef PTC_MAP_SVH
`define PTC_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PTC_A_CTRL 8'h00
`define PTC_A_MODE 8'h04
`define PTC_A_PRESET 8'h08
`define PTC_A_STATUS 8'h0C
`define PTC_A_COUNT 8'h10
`define PTC_A_BUFFER 8'h14
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PTC_C_COUNT 0
`define PTC_C_STOP 1
`define PTC_C_RESET 2
`define PTC_C_DISP 3
`define PTC_C_TB 4
`define PTC_M_LOCK 0
`define PTC_M_IFACE 1
`define PTC_M_RESTART 2
`define PTC_P_M 0
`define PTC_P_N 4
`define PTC_P_P 8
// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define PTC_RST_DIGIT 4'h0
`define PTC_MN_MAX 4'h9
`define PTC_P_MAX 4'h6
// ----------------------------------------
// Timing
// ----------------------------------------
`define PTC_CLK_HZ 25000000
`define PTC_TB_SEC_MS 10
`define PTC_TB_MIN_MS 600
`define PTC_DWELL_SHORT_S 1
`define PTC_DWELL_LONG_S 10
`define PTC_OVF_US 20
`define PTC_TB_SEC_CYC (`PTC_CLK_HZ / 1000 * `PTC_TB_SEC_MS)
`define PTC_TB_MIN_CYC (`PTC_CLK_HZ / 1000 * `PTC_TB_MIN_MS)
`define PTC_DWELL_SHORT_CYC (`PTC_CLK_HZ * `PTC_DWELL_SHORT_S)
`define PTC_DWELL_LONG_CYC (`PTC_CLK_HZ * `PTC_DWELL_LONG_S)
`define PTC_OVF_CYC (`PTC_CLK_HZ / 1000000 * `PTC_OVF_US)
`endif

// >>> ptc_panel.sv
`timescale 1ns/10ps
module ptc_panel (
    input wire logic core_clk_i,
    input wire logic go_i,
    input wire logic [2:0] which_i,
    output ptc_pkg::ptc_buttons_s buttons_o
);
    logic [3:0] cnt_q = 4'h0;
    logic [2:0] which_q = 3'h0;
    always_ff @(posedge core_clk_i) begin
        if (go_i) begin
            cnt_q <= 4'hC;
            which_q <= which_i;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end
    // Button held six cycles, then released six
    assign buttons_o = ptc_pkg::ptc_buttons_s'((cnt_q > 4'h6) ? (7'h01 << which_q) : 7'h00);
endmodule

// >>> ptc_pkg.sv
package ptc_pkg;
    typedef enum logic [1:0] {
        PTC_DISP_COUNT = 2'b01,
        PTC_DISP_PRESET = 2'b10
    } ptc_disp_e;
    typedef enum logic [2:0] {
        PTC_TB_SEC = 3'b001,
        PTC_TB_MIN = 3'b010,
        PTC_TB_EXT = 3'b100
    } ptc_tb_e;
    typedef enum logic [2:0] {
        PTC_SEL_M = 3'b001,
        PTC_SEL_N = 3'b010,
        PTC_SEL_P = 3'b100
    } ptc_sel_e;
    typedef struct packed {
        logic display;
        logic select;
        logic advance;
        logic timebase;
        logic count;
        logic stop;
        logic reset;
    } ptc_buttons_s;
    typedef struct packed {
        logic overflow_lamp;
        logic remote_lamp;
        logic gate_lamp;
        logic [1:0] disp;
        logic [2:0] tb;
        logic [2:0] sel;
    } ptc_lamps_s;
    typedef struct packed {
        logic [31:0] digits;
        logic [7:0] blank;
        logic point;
    } ptc_display_s;
endpackage

// >>> ptc_top.sv
`timescale 1ns/10ps
`include "ptc_map.svh"
module ptc_top #(
    parameter logic [27:0] TB_SEC_CYC = 28'(`PTC_TB_SEC_CYC),
    parameter logic [27:0] TB_MIN_CYC = 28'(`PTC_TB_MIN_CYC),
    parameter logic [27:0] DWELL_SHORT_CYC = 28'(`PTC_DWELL_SHORT_CYC),
    parameter logic [27:0] DWELL_LONG_CYC = 28'(`PTC_DWELL_LONG_CYC)
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire ptc_pkg::ptc_buttons_s buttons_i,
    input wire logic gate_i,
    input wire logic pos_event_i,
    input wire logic negative_event_input_i,
    input wire logic recycle_jumper_i,
    input wire logic dwell_length_jumper_i,
    input wire logic count_source_jumper_i,
    input wire logic print_loop_ctrl_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output ptc_pkg::ptc_lamps_s lamps_o,
    output ptc_pkg::ptc_display_s display_o,
    output logic gate_level_out_o,
    output logic overflow_pulse_out_o
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [13:0] pin_raw;
    logic [13:0] s1_q;
    logic [13:0] s2_q;
    logic [13:0] s3_q;
    assign pin_raw = {buttons_i, gate_i, pos_event_i, negative_event_input_i,
                      recycle_jumper_i, dwell_length_jumper_i,
                      count_source_jumper_i, print_loop_ctrl_i};
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            s1_q <= 14'h0000;
            s2_q <= 14'h0000;
            s3_q <= 14'h0000;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    wire [13:0] rise = s2_q & ~s3_q;
    wire gate_s = s2_q[6];
    wire rec_j = s2_q[3];
    wire dwl_j = s2_q[2];
    wire src_j = s2_q[1];
    wire ploop = s2_q[0];
    wire ev = rise[5] | rise[4];
    // ----------------------------------------
    // Register bus decode
    // ----------------------------------------
    logic [2:0] mode_q;
    wire wr_ctrl = wr_i & (addr_i == `PTC_A_CTRL);
    wire wr_mode = wr_i & (addr_i == `PTC_A_MODE);
    wire wr_pre = wr_i & (addr_i == `PTC_A_PRESET);
    wire rd_buf = rd_i & (addr_i == `PTC_A_BUFFER);
    wire h_count = wr_ctrl & wdata_i[`PTC_C_COUNT];
    wire h_stop = wr_ctrl & wdata_i[`PTC_C_STOP];
    wire h_reset = wr_ctrl & wdata_i[`PTC_C_RESET];
    wire h_disp = wr_ctrl & wdata_i[`PTC_C_DISP];
    wire h_tb = wr_ctrl & wdata_i[`PTC_C_TB];
    wire lock = mode_q[`PTC_M_LOCK];
    wire iface = mode_q[`PTC_M_IFACE];
    wire restart = mode_q[`PTC_M_RESTART];
    wire [3:0] w_m = wdata_i[`PTC_P_M +: 4];
    wire [3:0] w_n = wdata_i[`PTC_P_N +: 4];
    wire [3:0] w_p = wdata_i[`PTC_P_P +: 4];
    // ----------------------------------------
    // Panel buttons
    // ----------------------------------------
    wire pe = ~lock;
    wire b_disp = rise[13] & pe;
    wire b_sel = rise[12] & pe;
    wire b_adv = rise[11] & pe;
    wire b_tb = rise[10] & pe;
    wire b_count = rise[9] & pe;
    wire b_stop = rise[8] & pe;
    wire b_reset = rise[7] & pe;
    // ----------------------------------------
    // Display, time base and digit select
    // ----------------------------------------
    ptc_pkg::ptc_disp_e disp_q;
    ptc_pkg::ptc_disp_e disp_d;
    ptc_pkg::ptc_tb_e tb_q;
    ptc_pkg::ptc_tb_e tb_d;
    ptc_pkg::ptc_sel_e sel_q;
    ptc_pkg::ptc_sel_e sel_d;
    wire show_pre = (disp_q == ptc_pkg::PTC_DISP_PRESET);
    wire do_disp = b_disp | h_disp;
    wire do_tb = b_tb | h_tb;
    wire do_sel = b_sel & show_pre;
    wire do_adv = b_adv & show_pre;
    always_comb begin
        disp_d = disp_q;
        if (do_disp) begin
            case (disp_q)
                ptc_pkg::PTC_DISP_COUNT: disp_d = ptc_pkg::PTC_DISP_PRESET;
                ptc_pkg::PTC_DISP_PRESET: disp_d = ptc_pkg::PTC_DISP_COUNT;
                default: disp_d = ptc_pkg::PTC_DISP_COUNT;
            endcase
        end
    end
    always_comb begin
        tb_d = tb_q;
        if (do_tb) begin
            case (tb_q)
                ptc_pkg::PTC_TB_SEC: tb_d = ptc_pkg::PTC_TB_MIN;
                ptc_pkg::PTC_TB_MIN: tb_d = ptc_pkg::PTC_TB_EXT;
                ptc_pkg::PTC_TB_EXT: tb_d = ptc_pkg::PTC_TB_SEC;
                default: tb_d = ptc_pkg::PTC_TB_SEC;
            endcase
        end
    end
    always_comb begin
        sel_d = sel_q;
        if (do_sel) begin
            case (sel_q)
                ptc_pkg::PTC_SEL_M: sel_d = ptc_pkg::PTC_SEL_N;
                ptc_pkg::PTC_SEL_N: sel_d = ptc_pkg::PTC_SEL_P;
                ptc_pkg::PTC_SEL_P: sel_d = ptc_pkg::PTC_SEL_M;
                default: sel_d = ptc_pkg::PTC_SEL_M;
            endcase
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            disp_q <= ptc_pkg::PTC_DISP_COUNT;
            tb_q <= ptc_pkg::PTC_TB_SEC;
            sel_q <= ptc_pkg::PTC_SEL_M;
        end else begin
            disp_q <= disp_d;
            tb_q <= tb_d;
            sel_q <= sel_d;
        end
    end
    // ----------------------------------------
    // Preset digits
    // ----------------------------------------
    logic [3:0] m_q;
    logic [3:0] n_q;
    logic [3:0] p_q;
    wire adv_m = do_adv & (sel_q == ptc_pkg::PTC_SEL_M);
    wire adv_n = do_adv & (sel_q == ptc_pkg::PTC_SEL_N);
    wire adv_p = do_adv & (sel_q == ptc_pkg::PTC_SEL_P);
    wire [3:0] m_inc = (m_q >= `PTC_MN_MAX) ? 4'h0 : m_q + 4'h1;
    wire [3:0] n_inc = (n_q >= `PTC_MN_MAX) ? 4'h0 : n_q + 4'h1;
    wire [3:0] p_inc = (p_q >= `PTC_P_MAX) ? 4'h0 : p_q + 4'h1;
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            m_q <= `PTC_RST_DIGIT;
            n_q <= `PTC_RST_DIGIT;
            p_q <= `PTC_RST_DIGIT;
        end else if (wr_pre) begin
            if (w_m <= `PTC_MN_MAX) m_q <= w_m;
            if (w_n <= `PTC_MN_MAX) n_q <= w_n;
            if (w_p <= `PTC_P_MAX) p_q <= w_p;
        end else begin
            if (adv_m) m_q <= m_inc;
            if (adv_n) n_q <= n_inc;
            if (adv_p) p_q <= p_inc;
        end
    end
    // ----------------------------------------
    // Preset target
    // ----------------------------------------
    function automatic logic [19:0] pow10(input logic [3:0] e);
        case (e)
            4'h0: pow10 = 20'h00001;
            4'h1: pow10 = 20'h0000A;
            4'h2: pow10 = 20'h00064;
            4'h3: pow10 = 20'h003E8;
            4'h4: pow10 = 20'h02710;
            4'h5: pow10 = 20'h186A0;
            4'h6: pow10 = 20'hF4240;
            default: pow10 = 20'h00001;
        endcase
    endfunction
    wire [6:0] mn = 7'(m_q * 4'hA) + 7'(n_q);
    wire [26:0] target = 27'(mn * pow10(p_q));
    logic [26:0] pre_q;
    wire reached = (mn != 7'h00) & (pre_q >= target);
    // ----------------------------------------
    // Run control and gate
    // ----------------------------------------
    logic run_q;
    logic reached_q;
    logic gate_q;
    wire host_ctrl = iface | ploop;
    wire auto_rs = iface & restart;
    wire hit = reached & ~reached_q;
    wire single_stop = hit & iface & ~restart;
    wire active = run_q & gate_s & ~reached;
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            run_q <= 1'b0;
            reached_q <= 1'b0;
            gate_q <= 1'b0;
        end else begin
            if (b_stop | h_stop | single_stop) begin
                run_q <= 1'b0;
            end else if (b_count | h_count) begin
                run_q <= 1'b1;
            end
            reached_q <= reached;
            gate_q <= active;
        end
    end
    // ----------------------------------------
    // Dwell and recycle
    // ----------------------------------------
    logic dwell_q;
    logic [27:0] dwc_q;
    wire dwell_on = rec_j & ~host_ctrl;
    wire [27:0] dlim = dwl_j ? DWELL_LONG_CYC : DWELL_SHORT_CYC;
    wire dwell_end = dwell_q & dwell_on & (dwc_q >= dlim - 28'h1);
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            dwell_q <= 1'b0;
            dwc_q <= 28'h0000000;
        end else if (!dwell_on | dwell_end) begin
            dwell_q <= 1'b0;
            dwc_q <= 28'h0000000;
        end else if (hit) begin
            dwell_q <= 1'b1;
            dwc_q <= 28'h0000000;
        end else if (dwell_q) begin
            dwc_q <= dwc_q + 28'h1;
        end
    end
    // ----------------------------------------
    // Clear sources
    // ----------------------------------------
    wire restart_hit = hit & auto_rs;
    wire full_clr = b_reset | h_reset | dwell_end;
    wire cnt_clr = full_clr | restart_hit;
    // ----------------------------------------
    // Time base prescaler
    // ----------------------------------------
    logic [27:0] psc_q;
    wire tb_ext = (tb_q == ptc_pkg::PTC_TB_EXT);
    wire [27:0] plim = (tb_q == ptc_pkg::PTC_TB_MIN) ? TB_MIN_CYC : TB_SEC_CYC;
    wire tick = active & (psc_q >= plim - 28'h1);
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            psc_q <= 28'h0000000;
        end else if (cnt_clr | tick) begin
            psc_q <= 28'h0000000;
        end else if (active) begin
            psc_q <= psc_q + 28'h1;
        end
    end
    // ----------------------------------------
    // Preset register count
    // ----------------------------------------
    wire pre_inc = active & (tb_ext ? ev : tick);
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            pre_q <= 27'h0000000;
        end else if (cnt_clr) begin
            pre_q <= 27'h0000000;
        end else if (pre_inc) begin
            pre_q <= pre_q + 27'h1;
        end
    end
    // ----------------------------------------
    // Eight decade counter
    // ----------------------------------------
    logic [31:0] cnt_q;
    logic [31:0] cnt_nx;
    logic [8:0] cy;
    wire cnt_ev = (src_j | tb_ext) ? ev : tick;
    assign cy[0] = active & cnt_ev;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_dec
            wire [3:0] dg = cnt_q[4*gi +: 4];
            wire nine = (dg == 4'h9);
            assign cy[gi+1] = cy[gi] & nine;
            assign cnt_nx[4*gi +: 4] = !cy[gi] ? dg : (nine ? 4'h0 : dg + 4'h1);
        end
    endgenerate
    wire ovf_ev = cy[8];
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            cnt_q <= 32'h00000000;
        end else if (cnt_clr) begin
            cnt_q <= 32'h00000000;
        end else begin
            cnt_q <= cnt_nx;
        end
    end
    // ----------------------------------------
    // Overflow lamp and pulse
    // ----------------------------------------
    logic ovf_q;
    logic [8:0] opc_q;
    logic opl_q;
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            ovf_q <= 1'b0;
            opc_q <= 9'h000;
            opl_q <= 1'b0;
        end else begin
            ovf_q <= ovf_ev | (ovf_q & ~full_clr);
            if (ovf_ev) begin
                opc_q <= 9'(`PTC_OVF_CYC);
            end else if (opc_q != 9'h000) begin
                opc_q <= opc_q - 9'h001;
            end
            opl_q <= ovf_ev | (opc_q > 9'h001);
        end
    end
    // ----------------------------------------
    // Restart buffer
    // ----------------------------------------
    logic [31:0] buf_q;
    logic bval_q;
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            buf_q <= 32'h00000000;
            bval_q <= 1'b0;
        end else begin
            if (restart_hit) begin
                buf_q <= cnt_q;
            end
            bval_q <= restart_hit | (bval_q & ~rd_buf);
        end
    end
    // ----------------------------------------
    // Mode register
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            mode_q <= 3'h0;
        end else if (wr_mode) begin
            mode_q <= wdata_i[2:0];
        end
    end
    // ----------------------------------------
    // Display formatting
    // ----------------------------------------
    wire time_view = ~show_pre & ~src_j & ~tb_ext;
    wire [31:0] dval = show_pre ? {20'h00000, m_q, n_q, p_q} : cnt_q;
    logic [8:0] lead;
    logic [7:0] blank;
    assign lead[8] = 1'b1;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_blank
            wire keep = (gi == 0) | (time_view & (gi < 3));
            assign lead[gi] = lead[gi+1] & (dval[4*gi +: 4] == 4'h0);
            assign blank[gi] = lead[gi] & ~keep;
        end
    endgenerate
    ptc_pkg::ptc_display_s disp_out_q;
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            disp_out_q <= '0;
        end else begin
            disp_out_q.digits <= dval;
            disp_out_q.blank <= blank;
            disp_out_q.point <= time_view;
        end
    end
    // ----------------------------------------
    // Read data
    // ----------------------------------------
    wire [31:0] st = {24'h000000, bval_q, tb_q, show_pre, reached, gate_q, ovf_q};
    wire [31:0] pre_rd = {20'h00000, p_q, n_q, m_q};
    logic [31:0] rmux;
    logic [31:0] rd_q;
    always_comb begin
        case (addr_i)
            `PTC_A_MODE: rmux = {29'h00000000, mode_q};
            `PTC_A_PRESET: rmux = pre_rd;
            `PTC_A_STATUS: rmux = st;
            `PTC_A_COUNT: rmux = cnt_q;
            `PTC_A_BUFFER: rmux = buf_q;
            default: rmux = 32'h00000000;
        endcase
    end
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            rd_q <= 32'h00000000;
        end else begin
            rd_q <= rd_i ? rmux : 32'h00000000;
        end
    end
    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign rdata_o = rd_q;
    assign display_o = disp_out_q;
    assign gate_level_out_o = gate_q;
    assign overflow_pulse_out_o = opl_q;
    assign lamps_o.overflow_lamp = ovf_q;
    assign lamps_o.remote_lamp = lock;
    assign lamps_o.gate_lamp = gate_q;
    assign lamps_o.disp = disp_q;
    assign lamps_o.tb = tb_q;
    assign lamps_o.sel = sel_q;
endmodule

// >>> ptc_top_bench.sv
`timescale 1ns/10ps
module ptc_top_bench;
    logic core_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic go = 1'b0;
    logic [2:0] which = 3'h0;
    ptc_pkg::ptc_buttons_s btn;
    logic gate = 1'b1;
    logic pev = 1'b0;
    logic nev = 1'b0;
    logic rcy = 1'b0;
    logic dwl = 1'b1;
    logic src = 1'b1;
    logic plc = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    ptc_pkg::ptc_lamps_s lamps;
    ptc_pkg::ptc_display_s dsp;
    logic gate_out;
    logic ovf_out;
    int num_errors = 0;
    int tests_run = 0;
    initial begin
        forever #20 core_clk_i = ~core_clk_i;
    end
    ptc_panel i_ptc_panel (.core_clk_i(core_clk_i), .go_i(go), .which_i(which), .buttons_o(btn));
    ptc_top #(.TB_SEC_CYC(28'h4), .TB_MIN_CYC(28'h6), .DWELL_SHORT_CYC(28'h14), .DWELL_LONG_CYC(28'h32)) i_ptc_top (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .buttons_i(btn), .gate_i(gate), .pos_event_i(pev),
        .negative_event_input_i(nev), .recycle_jumper_i(rcy), .dwell_length_jumper_i(dwl),
        .count_source_jumper_i(src), .print_loop_ctrl_i(plc), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .lamps_o(lamps), .display_o(dsp), .gate_level_out_o(gate_out),
        .overflow_pulse_out_o(ovf_out));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    task automatic end_sim();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk_i);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk_i);
        rd <= 1'b0;
        @(posedge core_clk_i);
        chk("rdata", e, rdata);
    endtask
    task automatic press(input logic [2:0] b);
        @(posedge core_clk_i);
        which <= b;
        go <= 1'b1;
        @(posedge core_clk_i);
        go <= 1'b0;
        cyc(14);
    endtask
    task automatic ev(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk_i);
            pev <= ~i[0];
            nev <= i[0];
            cyc(3);
            pev <= 1'b0;
            nev <= 1'b0;
            cyc(3);
        end
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        cyc(20000);
        num_errors++;
        end_sim();
    end
    initial begin
        cyc(20);
        reset_n_i <= 1'b1;
        cyc(3);
        chk("lamps", 32'h049, 32'(lamps));
        chk("gate", 32'h0, 32'(gate_out));
        chk("ovf_pulse", 32'h0, 32'(ovf_out));
        rchk(8'h08, 32'h0);
        rchk(8'h20, 32'h0);
        rchk(8'h00, 32'h0);
        wreg(8'h08, 32'h602);
        wreg(8'h08, 32'hF0A);
        rchk(8'h08, 32'h602);
        press(3'h6);
        chk("disp", 32'h2, 32'(lamps.disp));
        press(3'h5);
        press(3'h5);
        chk("sel", 32'h4, 32'(lamps.sel));
        press(3'h4);
        rchk(8'h08, 32'h002);
        chk("digits", 32'h200, dsp.digits);
        press(3'h5);
        for (int i = 0; i < 8; i++) begin
            press(3'h4);
        end
        rchk(8'h08, 32'h000);
        press(3'h6);
        press(3'h4);
        press(3'h5);
        chk("sel", 32'h1, 32'(lamps.sel));
        rchk(8'h08, 32'h0);
        for (int i = 0; i < 3; i++) begin
            press(3'h3);
            chk("tb", 32'(3'b001 << ((i + 1) % 3)), 32'(lamps.tb));
        end
        wreg(8'h04, 32'h1);
        press(3'h6);
        chk("remote", 32'h1, 32'(lamps.remote_lamp));
        chk("disp", 32'h1, 32'(lamps.disp));
        wreg(8'h04, 32'h0);
        wreg(8'h00, 32'h10);
        wreg(8'h00, 32'h10);
        wreg(8'h08, 32'h050);
        wreg(8'h00, 32'h1);
        cyc(2);
        chk("gate", 32'h1, 32'(gate_out));
        chk("gate_lamp", 32'h1, 32'(lamps.gate_lamp));
        ev(8);
        rchk(8'h10, 32'h5);
        chk("gate", 32'h0, 32'(gate_out));
        wreg(8'h00, 32'h4);
        rchk(8'h10, 32'h0);
        rchk(8'h08, 32'h050);
        ev(2);
        gate <= 1'b0;
        cyc(5);
        chk("gate_lamp", 32'h0, 32'(lamps.gate_lamp));
        ev(2);
        rchk(8'h10, 32'h2);
        gate <= 1'b1;
        wreg(8'h00, 32'h2);
        ev(2);
        rchk(8'h10, 32'h2);
        wreg(8'h04, 32'h6);
        rchk(8'h04, 32'h6);
        wreg(8'h00, 32'h4);
        wreg(8'h00, 32'h1);
        ev(7);
        rchk(8'h0C, 32'hC2);
        rchk(8'h14, 32'h5);
        rchk(8'h10, 32'h2);
        wreg(8'h04, 32'h2);
        wreg(8'h00, 32'h4);
        ev(7);
        rchk(8'h10, 32'h5);
        rchk(8'h0C, 32'h44);
        wreg(8'h00, 32'h4);
        cyc(3);
        chk("gate", 32'h0, 32'(gate_out));
        wreg(8'h04, 32'h0);
        wreg(8'h08, 32'h300);
        wreg(8'h00, 32'h4);
        wreg(8'h00, 32'h1);
        ev(8);
        rchk(8'h10, 32'h8);
        rcy <= 1'b1;
        wreg(8'h08, 32'h050);
        wreg(8'h00, 32'h4);
        ev(5);
        rchk(8'h10, 32'h5);
        cyc(60);
        rchk(8'h10, 32'h0);
        chk("gate", 32'h1, 32'(gate_out));
        plc <= 1'b1;
        ev(5);
        cyc(60);
        rchk(8'h10, 32'h5);
        plc <= 1'b0;
        rcy <= 1'b0;
        src <= 1'b0;
        wreg(8'h00, 32'h10);
        wreg(8'h08, 32'h030);
        wreg(8'h00, 32'h4);
        cyc(30);
        rchk(8'h10, 32'h3);
        chk("blank", 32'hF8, 32'(dsp.blank));
        chk("point", 32'h1, 32'(dsp.point));
        end_sim();
    end
endmodule
